// >>> fcs_pkg.sv
// fcs_pkg: offsets, field positions, codes and carrier types for the
// flash controller status block.
// assumes the sequencer and the apb master share clk_i with the block.
package fcs_pkg;

  // apb byte offsets
  localparam logic [11:0] OFF_STATUS = 12'h000;
  localparam logic [11:0] OFF_IRQ_EN = 12'h004;
  localparam logic [11:0] OFF_CMD = 12'h008;
  localparam logic [11:0] OFF_ADDR = 12'h00C;
  localparam logic [11:0] OFF_DLO = 12'h010;
  localparam logic [11:0] OFF_DHI = 12'h014;
  localparam logic [11:0] OFF_IRQ_ST = 12'h018;

  // status word field positions
  localparam int unsigned ST_BUSY = 0;
  localparam int unsigned ST_LOCK = 1;
  localparam int unsigned ST_DONE = 2;
  localparam int unsigned ST_WNF = 3;
  localparam int unsigned ST_RES_LSB = 4;
  localparam int unsigned ST_ECC_LSB = 7;

  // interrupt bit positions, shared by enable and status
  localparam int unsigned IRQ_DONE = 0;
  localparam int unsigned IRQ_WNF = 1;
  localparam int unsigned IRQ_FAIL = 2;

  // signature ecc result codes
  localparam logic [1:0] ECC_CLEAN = 2'h0;
  localparam logic [1:0] ECC_DOUBLE_UNCORRECTED = 2'h1;
  localparam logic [1:0] ECC_SINGLE_FIXED = 2'h2;
  localparam logic [1:0] ECC_SINGLE_AND_DOUBLE = 2'h3;

  // command result codes
  localparam logic [1:0] RES_OK = 2'h0;
  localparam logic [1:0] RES_PROTECTED = 2'h1;
  localparam logic [1:0] RES_VERIFY = 2'h2;
  localparam logic [1:0] RES_ABORT = 2'h3;

  // reset values
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [2:0] RST_IRQ = 3'h0;
  localparam logic [4:0] RST_CMD = 5'h00;
  localparam logic [1:0] RST_RES = 2'h0;

  // command tracking states
  typedef enum logic [1:0] {
    CS_IDLE = 2'b01,
    CS_BUSY = 2'b10
  } fcs_cmd_state_e;

  // one-cycle events from the command sequencer, plus the sig_active level
  typedef struct packed {
    logic cmd_done;     // command finished
    logic wr_done;      // flash write finished
    logic wr_open;      // keyhole may be reloaded
    logic abort;        // finished by abort
    logic prot_err;     // hit a protected location
    logic verify_err;   // erase read-back not all ones
    logic sig_mismatch; // signature differs from stored one
    logic sig_start;    // signature command begins
    logic sig_active;   // signature command running (level)
    logic ecc_single;   // corrected single-bit error seen
    logic ecc_double;   // uncorrected double-bit error seen
  } fcs_seq_s;

endpackage

// >>> fcs_sticky.sv
// fcs_sticky: bank of sticky flags, set by hardware, cleared per bit.
// assumes set and clear are synchronous to clk_i.
`timescale 1ns/1ns
module fcs_sticky #(
  parameter int unsigned W = 4
) (
  input wire logic clk_i,          // system clock
  input wire logic rst_n_i,        // async reset, active low
  input wire logic [W-1:0] set_i,  // set pulses
  input wire logic [W-1:0] clr_i,  // clear pulses
  output logic [W-1:0] q_o         // flag levels
);

  ////////////////////////////////////////////////////////////////////
  // one flop per flag; set beats clear so no event is lost
  for (genvar i = 0; i < W; i++) begin : g_flag
    always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        q_o[i] <= 1'b0;
      end else if (set_i[i]) begin
        q_o[i] <= 1'b1;
      end else if (clr_i[i]) begin
        q_o[i] <= 1'b0;
      end
    end
  end

endmodule

// >>> fcs_keyhole.sv
// fcs_keyhole: address and data keyhole registers for flash writes.
// assumes write strobes come from a completed apb access.
`timescale 1ns/1ns
module fcs_keyhole (
  input wire logic clk_i,          // system clock
  input wire logic rst_n_i,        // async reset, active low
  input wire logic wr_addr_i,      // write address keyhole
  input wire logic wr_dlo_i,       // write low data keyhole
  input wire logic wr_dhi_i,       // write high data keyhole
  input wire logic [31:0] wdata_i, // write data
  input wire logic open_i,         // sequencer reopens keyhole
  output logic [31:0] addr_o,      // flash address
  output logic [31:0] dlo_o,       // low data word
  output logic [31:0] dhi_o,       // high data word
  output logic locked_o,           // keyhole closed
  output logic go_o                // write start pulse
);

  logic [2:0] seen_r;
  logic [2:0] seen_nxt;
  logic all_seen;
  logic wr_ok;

  ////////////////////////////////////////////////////////////////////
  // writes are dropped while locked, the command path stays open
  assign wr_ok = !locked_o;
  assign seen_nxt = seen_r | {wr_dhi_i & wr_ok, wr_dlo_i & wr_ok, wr_addr_i & wr_ok};
  assign all_seen = &seen_nxt && !locked_o;

  // data holding registers
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      addr_o <= fcs_pkg::RST_WORD;
      dlo_o <= fcs_pkg::RST_WORD;
      dhi_o <= fcs_pkg::RST_WORD;
    end else begin
      if (wr_addr_i && wr_ok) addr_o <= wdata_i;
      if (wr_dlo_i && wr_ok) dlo_o <= wdata_i;
      if (wr_dhi_i && wr_ok) dhi_o <= wdata_i;
    end
  end

  // lock once all three are loaded and the write is launched
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      seen_r <= 3'h0;
      locked_o <= 1'b0;
      go_o <= 1'b0;
    end else begin
      go_o <= all_seen;
      if (all_seen) begin
        seen_r <= 3'h0;
        locked_o <= 1'b1;
      end else begin
        seen_r <= seen_nxt;
        if (open_i) locked_o <= 1'b0;
      end
    end
  end

endmodule

// >>> fcs_top.sv
// fcs_top: status, result and interrupt logic of the flash controller,
// with its apb register slave and the keyhole write path.
// assumes an apb master on clk_i and a sequencer giving one-cycle
// events and the sig_active level in fcs_pkg::fcs_seq_s on the same clock.
//
// The register addresses and register access over APB were left to the implementer.
`timescale 1ns/1ns

// Notes on behaviour
// - clean signature check reads ecc field 00
// - double-bit errors in signature give 01
// - single corrected error in signature gives 10
// - both error kinds in signature give 11
// - successful command or write gives result 00
// - protected location access gives result 01
// - erase read-back not all ones gives 10
// - signature mismatch gives read-verify code 10
// - aborted command or write gives result 11
// - write-nearly-finished, bit 3, at earliest reload
// - done flag, bit 2, holds until status read
// - keyhole-locked, bit 1, read-only after write launch
// - locked keyholes reject writes, command stays writable
// - busy, bit 0, high while command executes
// - done interrupt when its enable is set
// - fail interrupt on error result when enabled
module fcs_top (
  input wire logic clk_i,                 // system clock, 125 MHz
  input wire logic rst_n_i,               // async reset, active low
  input wire logic psel_i,                // apb select
  input wire logic penable_i,             // apb enable
  input wire logic pwrite_i,              // apb direction
  input wire logic [11:0] paddr_i,        // apb byte address
  input wire logic [31:0] pwdata_i,       // apb write data
  output logic [31:0] prdata_o,           // apb read data
  output logic pready_o,                  // apb ready
  output logic pslverr_o,                 // apb error, unmapped address
  input wire fcs_pkg::fcs_seq_s seq_i,    // sequencer events
  output logic cmd_go_o,                  // command issue pulse
  output logic [4:0] cmd_code_o,          // issued command code
  output logic wr_go_o,                   // keyhole write start pulse
  output logic [31:0] flash_addr_o,       // keyhole address
  output logic [31:0] flash_data_lo_o,    // keyhole low data
  output logic [31:0] flash_data_hi_o,    // keyhole high data
  output logic irq_o                      // interrupt, level
);

  ////////////////////////////////////////////////////////////////////
  // declarations

  // apb decode and read path
  logic setup;
  logic acc;
  logic wr_acc;
  logic rd_acc;
  logic hit_status;
  logic hit_irq_en;
  logic hit_cmd;
  logic hit_addr;
  logic hit_dlo;
  logic hit_dhi;
  logic hit_irq_st;
  logic mapped;
  logic [31:0] rdata_mux;
  logic [31:0] status_word;
  logic [31:0] prdata_nxt;
  logic pready_nxt;
  logic unmapped;
  logic rd_status;
  logic wr_irq_en;
  logic wr_irq_st;
  logic wr_key_addr;
  logic wr_key_dlo;
  logic wr_key_dhi;
  logic [31:0] irq_en_word;
  logic [31:0] cmd_word;
  logic [31:0] irq_st_word;

  // status flags and fields
  logic [3:0] rc_set;
  logic [3:0] rc_clr;
  logic [3:0] rc_q;
  logic [1:0] sig_ecc_result;
  logic write_nearly_finished;
  logic cmd_finished_flag;
  logic keyhole_locked;
  logic cmd_executing;
  logic sig_restart;
  logic ecc_seen_double;
  logic ecc_seen_single;

  // command result
  logic completion;
  logic [1:0] res_code;
  logic res_is_error;
  logic [1:0] cmd_result_code_r;
  logic [1:0] cmd_result_code_nxt;

  // interrupt enable and status
  logic [2:0] irq_en_r;
  logic [2:0] irq_st_q;
  logic [2:0] irq_set;
  logic [2:0] irq_clr;

  // command issue and busy tracking
  logic [4:0] cmd_reg_r;
  logic issue;
  logic cmd_nonzero;
  logic [4:0] cmd_wdata;
  fcs_pkg::fcs_cmd_state_e cs_r;
  fcs_pkg::fcs_cmd_state_e cs_nxt;

  ////////////////////////////////////////////////////////////////////
  // apb phase decode; ready is registered so the slave answers in the
  // first access cycle with no wait states. every register action keys
  // on the completed access (psel, penable and pready all high), never
  // on the setup cycle, so a master that stalls in setup does no harm
  assign setup = psel_i && !penable_i;
  assign acc = psel_i && penable_i && pready_o;
  assign wr_acc = acc && pwrite_i;
  assign rd_acc = acc && !pwrite_i;
  assign pready_nxt = setup;

  // address decode
  assign hit_status = paddr_i == fcs_pkg::OFF_STATUS;
  assign hit_irq_en = paddr_i == fcs_pkg::OFF_IRQ_EN;
  assign hit_cmd = paddr_i == fcs_pkg::OFF_CMD;
  assign hit_addr = paddr_i == fcs_pkg::OFF_ADDR;
  assign hit_dlo = paddr_i == fcs_pkg::OFF_DLO;
  assign hit_dhi = paddr_i == fcs_pkg::OFF_DHI;
  assign hit_irq_st = paddr_i == fcs_pkg::OFF_IRQ_ST;
  assign mapped = hit_status | hit_irq_en | hit_cmd | hit_addr | hit_dlo | hit_dhi
                | hit_irq_st;
  assign unmapped = !mapped;

  // completed-access strobes, one per register action; each lasts for
  // the single access cycle, so no action can be applied twice
  assign rd_status = rd_acc && hit_status;
  assign wr_irq_en = wr_acc && hit_irq_en;
  assign wr_irq_st = wr_acc && hit_irq_st;
  assign wr_key_addr = wr_acc && hit_addr;
  assign wr_key_dlo = wr_acc && hit_dlo;
  assign wr_key_dhi = wr_acc && hit_dhi;

  ////////////////////////////////////////////////////////////////////
  // status word assembly; bit 6 and the upper bits stay zero.
  // map: [8:7] signature ecc, [5:4] result, [3] nearly finished,
  // [2] done, [1] keyhole locked, [0] busy. busy and locked are live
  // levels; nearly-finished and done are sticky until read, the ecc bits until read or a signature start
  assign sig_ecc_result = rc_q[3:2];
  assign write_nearly_finished = rc_q[1];
  assign cmd_finished_flag = rc_q[0];
  assign cmd_executing = cs_r == fcs_pkg::CS_BUSY;

  always_comb begin
    status_word = fcs_pkg::RST_WORD;
    status_word[fcs_pkg::ST_ECC_LSB +: 2] = sig_ecc_result;
    status_word[fcs_pkg::ST_RES_LSB +: 2] = cmd_result_code_r;
    status_word[fcs_pkg::ST_WNF] = write_nearly_finished;
    status_word[fcs_pkg::ST_DONE] = cmd_finished_flag;
    status_word[fcs_pkg::ST_LOCK] = keyhole_locked;
    status_word[fcs_pkg::ST_BUSY] = cmd_executing;
  end

  // per-register read words; the write-nearly enable is stored and
  // drives the interrupt, but reads back as zero
  assign irq_en_word = {29'h0, irq_en_r[2], 1'b0, irq_en_r[0]};
  assign cmd_word = {27'h0, cmd_reg_r};
  assign irq_st_word = {29'h0, irq_st_q};

  // read mux; an unmapped address reads as zero
  assign rdata_mux =
      hit_status ? status_word :
      hit_irq_en ? irq_en_word :
      hit_cmd ? cmd_word :
      hit_addr ? flash_addr_o :
      hit_dlo ? flash_data_lo_o :
      hit_dhi ? flash_data_hi_o :
      hit_irq_st ? irq_st_word :
      fcs_pkg::RST_WORD;

  // data is captured in setup and held through the access phase; the
  // read-clear logic below keys on this captured copy, so it clears
  // exactly what software was shown
  assign prdata_nxt = (setup && !pwrite_i) ? rdata_mux : prdata_o;

  // apb response registers; the error flag rises with ready for an
  // unmapped address and the access is otherwise ignored
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prdata_o <= fcs_pkg::RST_WORD;
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
    end else begin
      prdata_o <= prdata_nxt;
      pready_o <= pready_nxt;
      pslverr_o <= setup && unmapped;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // read-clear flags: only the bits that were actually returned get
  // cleared, so an event landing between setup and access survives
  assign rc_set[0] = seq_i.cmd_done;
  assign rc_set[1] = seq_i.wr_open;
  assign rc_set[2] = ecc_seen_double;
  assign rc_set[3] = ecc_seen_single;

  // ecc events count only while a signature check runs; ecc events from ordinary
  // reads are dropped here and must not leak into this field
  assign ecc_seen_double = seq_i.sig_active && seq_i.ecc_double;
  assign ecc_seen_single = seq_i.sig_active && seq_i.ecc_single;

  // a new signature check starts from the clean code; the other flags
  // clear only through a completed status read
  assign sig_restart = seq_i.sig_start;
  assign rc_clr[0] = rd_status && prdata_o[fcs_pkg::ST_DONE];
  assign rc_clr[1] = rd_status && prdata_o[fcs_pkg::ST_WNF];
  assign rc_clr[2] = sig_restart
                   || (rd_status && prdata_o[fcs_pkg::ST_ECC_LSB]);
  assign rc_clr[3] = sig_restart
                   || (rd_status && prdata_o[fcs_pkg::ST_ECC_LSB + 1]);

  // set wins over the read clear inside the flag bank
  fcs_sticky #(
    .W(4)
  ) u_rc_flags (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .set_i(rc_set),
    .clr_i(rc_clr),
    .q_o(rc_q)
  );

  ////////////////////////////////////////////////////////////////////
  // result code, abort outranks protection, which outranks verify
  assign completion = seq_i.cmd_done || seq_i.wr_done;

  assign res_code =
      seq_i.abort ? fcs_pkg::RES_ABORT :
      seq_i.prot_err ? fcs_pkg::RES_PROTECTED :
      (seq_i.verify_err || seq_i.sig_mismatch) ? fcs_pkg::RES_VERIFY :
      fcs_pkg::RES_OK;

  assign res_is_error = res_code != fcs_pkg::RES_OK;
  assign cmd_result_code_nxt = completion ? res_code : cmd_result_code_r;

  // result holds until the next completion; it is not read-clear, so
  // software may read the status several times and see the same code.
  // qualifiers outside a completion cycle are ignored on purpose
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cmd_result_code_r <= fcs_pkg::RST_RES;
    end else begin
      cmd_result_code_r <= cmd_result_code_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // interrupt status, write one to clear; set wins in the bank, so an
  // event that lands on the clearing write is still reported
  assign irq_set[fcs_pkg::IRQ_DONE] = completion;
  assign irq_set[fcs_pkg::IRQ_WNF] = seq_i.wr_open;
  assign irq_set[fcs_pkg::IRQ_FAIL] = completion && res_is_error;
  assign irq_clr = wr_irq_st ? pwdata_i[2:0] : 3'h0;

  fcs_sticky #(
    .W(3)
  ) u_irq_flags (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .set_i(irq_set),
    .clr_i(irq_clr),
    .q_o(irq_st_q)
  );

  // enables and the level interrupt; the output is registered, so it
  // follows a status or enable change one clock later
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_en_r <= fcs_pkg::RST_IRQ;
      irq_o <= 1'b0;
    end else begin
      if (wr_irq_en) irq_en_r <= pwdata_i[2:0];
      irq_o <= |(irq_st_q & irq_en_r);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // command register stays writable even while the keyhole is locked
  assign issue = wr_acc && hit_cmd;
  assign cmd_wdata = pwdata_i[4:0];
  assign cmd_nonzero = cmd_wdata != fcs_pkg::RST_CMD;

  // busy tracking; a done in the issue cycle is taken as the old one.
  // writing the idle code still pulses cmd_go_o and loads cmd_code_o, but busy stays low for it.
  // a second command issued while busy merges into the same busy span
  always_comb begin
    cs_nxt = cs_r;
    unique case (cs_r)
      fcs_pkg::CS_IDLE: begin
        if (issue && cmd_nonzero) cs_nxt = fcs_pkg::CS_BUSY;
      end
      fcs_pkg::CS_BUSY: begin
        if (seq_i.cmd_done) cs_nxt = fcs_pkg::CS_IDLE;
      end
      default: cs_nxt = fcs_pkg::CS_IDLE;
    endcase
  end

  // command issue registers
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cs_r <= fcs_pkg::CS_IDLE;
      cmd_reg_r <= fcs_pkg::RST_CMD;
      cmd_go_o <= 1'b0;
      cmd_code_o <= fcs_pkg::RST_CMD;
    end else begin
      cs_r <= cs_nxt;
      cmd_go_o <= issue;
      if (issue) begin
        cmd_reg_r <= cmd_wdata;
        cmd_code_o <= cmd_wdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // keyhole path; lock stays until the sequencer reopens it. a keyhole
  // write while locked is dropped silently with no bus error, so
  // software must poll the locked bit before reloading
  fcs_keyhole u_keyhole (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .wr_addr_i(wr_key_addr),
    .wr_dlo_i(wr_key_dlo),
    .wr_dhi_i(wr_key_dhi),
    .wdata_i(pwdata_i),
    .open_i(seq_i.wr_open),
    .addr_o(flash_addr_o),
    .dlo_o(flash_data_lo_o),
    .dhi_o(flash_data_hi_o),
    .locked_o(keyhole_locked),
    .go_o(wr_go_o)
  );

endmodule

// >>> fcs_top_asserts.sv
// fcs_top_asserts: port-level checks on fcs_top.
// assumes apb and sequencer events are synchronous to clk_i.
`timescale 1ns/1ns
module fcs_top_asserts (
  input wire logic clk_i,                  // clock
  input wire logic rst_n_i,                // async reset, active low
  input wire logic psel_i,                 // apb select
  input wire logic penable_i,              // apb enable
  input wire logic pwrite_i,               // apb direction
  input wire logic [11:0] paddr_i,         // apb address
  input wire logic [31:0] pwdata_i,        // apb write data
  input wire logic [31:0] prdata_o,        // apb read data
  input wire logic pready_o,               // apb ready
  input wire fcs_pkg::fcs_seq_s seq_i,     // sequencer events
  input wire logic cmd_go_o,               // command pulse
  input wire logic [4:0] cmd_code_o,       // command code
  input wire logic wr_go_o,                // write launch
  input wire logic [31:0] flash_addr_o,    // keyhole address
  input wire logic [31:0] flash_data_lo_o, // keyhole low data
  input wire logic [31:0] flash_data_hi_o  // keyhole high data
);
  //////////////////////////////
  // completed accesses, decoded once
  logic lk_r;
  logic [1:0] dn_r;
  wire acc = psel_i & penable_i & pready_o;
  wire wr_acc = acc & pwrite_i;
  wire st_rd = acc & !pwrite_i & (paddr_i == fcs_pkg::OFF_STATUS);
  wire kh_a = wr_acc & (paddr_i == fcs_pkg::OFF_ADDR);
  wire kh_l = wr_acc & (paddr_i == fcs_pkg::OFF_DLO);
  wire kh_h = wr_acc & (paddr_i == fcs_pkg::OFF_DHI);
  wire kh_wr = kh_a | kh_l | kh_h;
  // live copy of the keyhole lock: high with the launch pulse, low from
  // the edge after a reopen event
  wire lk_now = wr_go_o | lk_r;
  wire lk_nxt = lk_now & !seq_i.wr_open;
  // a set in the read cycle must win, so clear only what was returned
  wire [1:0] dn_nxt = {seq_i.wr_open, seq_i.cmd_done} | (dn_r & ~(st_rd ? prdata_o[3:2] : 2'h0));

  // shadow of lock and read-clear flags
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lk_r <= 1'b0;
      dn_r <= 2'h0;
    end else begin
      lk_r <= lk_nxt;
      dn_r <= dn_nxt;
    end
  end

  //////////////////////////////
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  a_cmd_issue: assert property (
    wr_acc && paddr_i == fcs_pkg::OFF_CMD && pwdata_i[4:0] != 5'h00
    |=> cmd_go_o && cmd_code_o == $past(pwdata_i[4:0])) else $error("command not issued");
  a_addr_locked: assert property (
    lk_now && kh_a |=> $stable(flash_addr_o)) else $error("locked address changed");
  a_dlo_locked: assert property (
    lk_now && kh_l |=> $stable(flash_data_lo_o)) else $error("locked low data changed");
  a_dhi_locked: assert property (
    lk_now && kh_h |=> $stable(flash_data_hi_o)) else $error("locked high data changed");
  a_go_cause: assert property (
    wr_go_o |-> $past(kh_wr)) else $error("launch without keyhole write");
  a_go_single: assert property (
    wr_go_o |=> !wr_go_o) else $error("launch longer than one cycle");
  a_status_zero: assert property (
    st_rd |-> prdata_o[31:9] == 23'h0 && !prdata_o[6]) else $error("reserved status bits set");
  a_flag_track: assert property (
    st_rd |-> prdata_o[3:2] == $past(dn_r)) else $error("read-clear flags wrong");
endmodule

bind fcs_top fcs_top_asserts u_fcs_top_asserts (
  .clk_i(clk_i),
  .rst_n_i(rst_n_i),
  .psel_i(psel_i),
  .penable_i(penable_i),
  .pwrite_i(pwrite_i),
  .paddr_i(paddr_i),
  .pwdata_i(pwdata_i),
  .prdata_o(prdata_o),
  .pready_o(pready_o),
  .seq_i(seq_i),
  .cmd_go_o(cmd_go_o),
  .cmd_code_o(cmd_code_o),
  .wr_go_o(wr_go_o),
  .flash_addr_o(flash_addr_o),
  .flash_data_lo_o(flash_data_lo_o),
  .flash_data_hi_o(flash_data_hi_o)
);

// >>> tb.sv
// tb: directed bench for fcs_top over apb and sequencer pulses.
// assumes fcs_pkg and the checker are compiled first.
`timescale 1ns/1ns
module tb;
  //////////////////////////////
  // driven and observed signals
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h0;
  fcs_pkg::fcs_seq_s seq_i = '0;
  logic [31:0] prdata_o, flash_addr_o, flash_data_lo_o, flash_data_hi_o, rq;
  logic pready_o, pslverr_o, cmd_go_o, wr_go_o, irq_o, re;
  logic [4:0] cmd_code_o;
  int num_errors = 0;
  int tests_run = 0;
  int go_n = 0;
  int cmd_n = 0;

  // 125 MHz clock and launch counters
  always #4 clk_i = ~clk_i;
  always @(posedge clk_i) if (wr_go_o === 1'b1) go_n <= go_n + 1;
  always @(posedge clk_i) if (cmd_go_o === 1'b1) cmd_n <= cmd_n + 1;

  fcs_top u_fcs_top (.clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .seq_i(seq_i), .cmd_go_o(cmd_go_o),
    .cmd_code_o(cmd_code_o), .wr_go_o(wr_go_o), .flash_addr_o(flash_addr_o),
    .flash_data_lo_o(flash_data_lo_o), .flash_data_hi_o(flash_data_hi_o),
    .irq_o(irq_o));

  //////////////////////////////
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      num_errors++;
      $display("CHECK FAILED %s exp %h seen %h", n, e, s);
    end
  endtask

  // one apb transfer; the request is held until pready is sampled
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 16);
    if (pready_o !== 1'b1) begin
      num_errors++;
      print_verdict();
    end
    rq = prdata_o;
    re = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [11:0] a);
    apb(1'b0, a, 32'h0);
  endtask

  task automatic st(input string n, input logic [31:0] m, input logic [31:0] e);
    rd(fcs_pkg::OFF_STATUS);
    chk(n, rq & m, e);
  endtask

  // one-cycle sequencer event
  task automatic ev(input logic [10:0] v);
    seq_i <= fcs_pkg::fcs_seq_s'(v);
    @(posedge clk_i);
    seq_i <= '0;
    @(posedge clk_i);
  endtask

  //////////////////////////////
  task automatic t_reset;
    st("status rst", 32'hFFFFFFFF, 32'h0);
    rd(12'hFFC);
    chk("unmapped", {31'h0, re}, 32'h1);
    $display("test reset done");
  endtask

  // every result code, plus the priority of abort
  task automatic t_result;
    logic [3:0] q [6] = '{4'h0, 4'h4, 4'h2, 4'h1, 4'h8, 4'hF};
    logic [1:0] c [6] = '{2'h0, 2'h1, 2'h2, 2'h2, 2'h3, 2'h3};
    wr(fcs_pkg::OFF_CMD, 32'h0);
    st("idle cmd", 32'h1, 32'h0);
    for (int i = 0; i < 6; i++) begin
      wr(fcs_pkg::OFF_CMD, 32'h1);
      st("busy", 32'h1, 32'h1);
      ev(11'h400 | {3'h0, q[i], 4'h0});
      st("result", 32'h37, {26'h0, c[i], 4'h4});
      st("done clr", 32'h34, {26'h0, c[i], 4'h0});
    end
    $display("test result done");
  endtask

  task automatic t_ecc;
    for (int i = 0; i < 4; i++) begin
      ev(11'h00C);
      ev(11'h004 | 11'(i));
      ev(11'h003);
      ev(11'h400);
      st("ecc", 32'h180, 32'(i) << 7);
    end
    $display("test ecc done");
  endtask

  task automatic t_keyhole;
    wr(fcs_pkg::OFF_ADDR, 32'h0000_1230);
    wr(fcs_pkg::OFF_DLO, 32'hA5A5_0001);
    wr(fcs_pkg::OFF_DHI, 32'h5A5A_0002);
    st("locked", 32'hA, 32'h2);
    chk("launches", 32'(go_n), 32'h1);
    chk("dhi", flash_data_hi_o, 32'h5A5A_0002);
    wr(fcs_pkg::OFF_ADDR, 32'hFFFF_0000);
    wr(fcs_pkg::OFF_DLO, 32'h0);
    wr(fcs_pkg::OFF_DHI, 32'h0);
    chk("addr held", flash_addr_o, 32'h0000_1230);
    chk("dlo held", flash_data_lo_o, 32'hA5A5_0001);
    chk("dhi held", flash_data_hi_o, 32'h5A5A_0002);
    wr(fcs_pkg::OFF_CMD, 32'h3);
    chk("cmd code", {27'h0, cmd_code_o}, 32'h3);
    ev(11'h100);
    chk("cmd pulses", 32'(cmd_n), 32'h8);
    st("reopen", 32'hA, 32'h8);
    st("wnf clr", 32'h8, 32'h0);
    ev(11'h400);
    $display("test keyhole done");
  endtask

  // event lands on the clearing edge of a status read
  task automatic t_race;
    ev(11'h400);
    fork
      st("race read", 32'h4, 32'h4);
      begin
        @(posedge clk_i);
        ev(11'h400);
      end
    join
    st("race kept", 32'h4, 32'h4);
    $display("test race done");
  endtask

  task automatic t_irq;
    wr(fcs_pkg::OFF_IRQ_ST, 32'h7);
    wr(fcs_pkg::OFF_IRQ_EN, 32'h7);
    rd(fcs_pkg::OFF_IRQ_EN);
    chk("irq en", rq, 32'h5);
    chk("irq idle", {31'h0, irq_o}, 32'h0);
    ev(11'h440);
    @(posedge clk_i);
    chk("irq fail", {31'h0, irq_o}, 32'h1);
    rd(fcs_pkg::OFF_IRQ_ST);
    chk("irq st", rq, 32'h5);
    wr(fcs_pkg::OFF_IRQ_EN, 32'h0);
    @(posedge clk_i);
    chk("irq masked", {31'h0, irq_o}, 32'h0);
    wr(fcs_pkg::OFF_IRQ_ST, 32'h7);
    ev(11'h200);
    rd(fcs_pkg::OFF_IRQ_ST);
    chk("wr done st", rq, 32'h1);
    wr(fcs_pkg::OFF_IRQ_EN, 32'h1);
    @(posedge clk_i);
    chk("irq done", {31'h0, irq_o}, 32'h1);
    wr(fcs_pkg::OFF_IRQ_ST, 32'h1);
    @(posedge clk_i);
    chk("irq clr", {31'h0, irq_o}, 32'h0);
    $display("test irq done");
  endtask

  //////////////////////////////
  // main sequence
  initial begin
    repeat (16) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    t_reset();
    t_result();
    t_ecc();
    t_keyhole();
    t_race();
    t_irq();
    print_verdict();
  end
endmodule
